// ==== include/bbg_map.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef BBG_MAP_SVH
`define BBG_MAP_SVH
`define BBG_REG_SYSCTL    4'h0
`define BBG_REG_STATUS    4'h4
`define BBG_PAGE_LSB      0
`define BBG_PAGE_MSB      2
`define BBG_FORCE_BIT     3
`define BBG_WAIT_LSB      4
`define BBG_WAIT_MSB      6
`define BBG_PAGE_RST      3'h0
`define BBG_WAIT_RST      3'h7
`define BBG_ST_BUSY       0
`define BBG_ST_GRANT      1
`define BBG_ST_HANG       2
`define BBG_ST_BOOTMODE   3
`define BBG_ST_EXTMODE    4
`define BBG_ST_ILLEGAL    5
`define BBG_ST_RUN        6
`define BBG_SYNC_LAT      4'h2
`define BBG_LEN_OFFSET    13'h0000
`define BBG_BYTE_HI       2'h3
`define BBG_BYTE_MID      2'h2
`define BBG_BYTE_LO       2'h1
`define BBG_TOP_WORD_LSB  3'h7
`define BBG_LANE_MSB      15
`define BBG_LANE_LSB      8
`define BBG_RELOC_BASE    14'h3800
`define BBG_EXT_START     14'h0000
`define BBG_NORMAL_BASE   14'h0000
`endif

// ==== include/bbg_pkg.sv ====
// types shared by the boot loader and bus grant logic
package bbg_pkg;
	typedef enum logic [1:0] {bs_idle, bs_len, bs_word} bbg_state_t;

	typedef struct packed {
		logic [13:0] addr;
		logic        addr_oe;
		logic [23:0] dout;
		logic        dout_oe_hi;
		logic        dout_oe_lo;
		logic        pms_n;
		logic        dms_n;
		logic        bms_n;
		logic        rd_n;
		logic        wr_n;
		logic        strobe_oe;
	} bbg_ext_out_t;

	typedef struct packed {
		logic        req;
		logic        is_dm;
		logic        wr;
		logic [13:0] addr;
		logic [23:0] wdata;
		logic [2:0]  ws;
		logic        go_mode;
	} bbg_core_req_t;

	typedef struct packed {
		logic        done;
		logic [23:0] rdata;
		logic        halt;
		logic        run;
	} bbg_core_rsp_t;

	typedef struct packed {
		logic        we;
		logic [10:0] addr;
		logic [23:0] data;
	} bbg_pm_wr_t;

	typedef struct packed {
		logic        relocate;
		logic [13:0] pm_ram_base;
		logic [13:0] start_addr;
		logic        illegal;
	} bbg_mode_t;
endpackage : bbg_pkg

// ==== logic/bbg_top.sv ====
// byte-wide boot sequencer and external bus request/grant logic
// Function
// RQ1: both straps low selects byte boot over the external memory interface
// RQ2: boot fetches one byte per access from 8-bit memory
// RQ3: boot space is eight pages of 8k bytes each
// RQ4: every fourth byte skipped except length byte; three bytes form a word
// RQ5: length byte read first, then bytes from top of page downwards
// RQ6: length is words/8 minus 1; zero covers 32 byte locations
// RQ7: boot after reset always loads page zero
// RQ8: software picks page then sets force bit to start boot
// RQ9: three-bit wait-state field 0..7 per boot access, resets to 7
// RQ10: boot access timed like external access, boot strobe replaces others
// RQ11: low 14 address bits on address bus, upper two on D23:D22
// RQ12: boot byte captured from data bits fifteen down to eight
// RQ13: external mode: no boot, program RAM at 0x3800, start at 0x0000
// RQ14: board never straps boot-source high with memory-map low
// RQ15: idle request granted next cycle, buses released, core halts
// RQ16: keep-running mode continues internal execution until external access
// RQ17: grant leaves core state untouched, serial ports keep running
// RQ18: request during access granted cycle after that access completes
// RQ19: grant may split two accesses; second waits for request withdrawal
// RQ20: grant drops same cycle release seen, drivers back, execution resumes
// RQ21: request honoured always; under reset grant follows request directly
// RQ22: during boot grant only after current byte and its wait states
// RQ23: hang output when ready but blocked; release ends grant and hang
// RQ24: outside master drives bus only while granted, stops before release
//
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bbg_map.svh"

module bbg_top (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	input  wire logic [3:0]             i_avs_address,
	input  wire logic                   i_avs_read,
	input  wire logic                   i_avs_write,
	input  wire logic [31:0]            i_avs_writedata,
	input  wire logic [3:0]             i_avs_byteenable,
	output logic [31:0]                 o_avs_readdata,
	output logic                        o_avs_waitrequest,
	input  wire logic                   i_memory_map_strap,
	input  wire logic                   i_boot_source_strap,
	input  wire logic                   i_bus_request_n,
	output logic                        o_bus_grant_n,
	output logic                        o_grant_hang_n,
	input  wire logic [23:0]            i_data_in,
	output bbg_pkg::bbg_ext_out_t       o_ext,
	input  wire bbg_pkg::bbg_core_req_t i_core,
	output bbg_pkg::bbg_core_rsp_t      o_core,
	output bbg_pkg::bbg_pm_wr_t         o_pm,
	output bbg_pkg::bbg_mode_t          o_mode
);
	import bbg_pkg::*;

	// pin synchronisers
	logic        br_s1_r, br_act;
	logic        memory_map_strap_s1_r, memory_map_strap_s2_r, bsrc_s1_r, bsrc_s2_r;
	logic [23:0] din_s1_r, din_s2_r;

	// no reset on request or straps: grant must follow the request under
	// reset, and the strap capture on the first edge must see real pins
	always_ff @(posedge i_clk) begin
		br_s1_r   <= ~i_bus_request_n;
		br_act    <= br_s1_r;
		memory_map_strap_s1_r <= i_memory_map_strap;
		memory_map_strap_s2_r <= memory_map_strap_s1_r;
		bsrc_s1_r <= i_boot_source_strap;
		bsrc_s2_r <= bsrc_s1_r;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			din_s1_r  <= 24'h000000;
			din_s2_r  <= 24'h000000;
		end else begin
			din_s1_r  <= i_data_in;
			din_s2_r  <= din_s1_r;
		end
	end

	// strap capture, one cycle after reset release
	logic strap_cap_r, mode_boot_r, mode_ext_r, mode_bad_r;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			strap_cap_r <= 1'b0;
			mode_boot_r <= 1'b0;
			mode_ext_r  <= 1'b0;
			mode_bad_r  <= 1'b0;
		end else if (!strap_cap_r) begin
			strap_cap_r <= 1'b1;
			mode_boot_r <= ~memory_map_strap_s2_r & ~bsrc_s2_r;  // [RQ1]
			mode_ext_r  <= memory_map_strap_s2_r & ~bsrc_s2_r;   // [RQ13]
			mode_bad_r  <= ~memory_map_strap_s2_r & bsrc_s2_r;   // [RQ14]
		end
	end
	wire reset_boot = ~strap_cap_r & ~memory_map_strap_s2_r & ~bsrc_s2_r;

	// control register
	logic [2:0] page_r, wait_r;
	logic       force_pulse;
	wire  wr_ctl = i_avs_write & i_avs_byteenable[0] &
		(i_avs_address == `BBG_REG_SYSCTL);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			page_r <= `BBG_PAGE_RST;
			wait_r <= `BBG_WAIT_RST;  // [RQ9]
		end else if (wr_ctl) begin
			page_r <= i_avs_writedata[`BBG_PAGE_MSB:`BBG_PAGE_LSB];  // [RQ8]
			wait_r <= i_avs_writedata[`BBG_WAIT_MSB:`BBG_WAIT_LSB];  // [RQ9]
		end
	end
	assign force_pulse = wr_ctl & i_avs_writedata[`BBG_FORCE_BIT];

	// external access engine, shared by boot and core
	logic        acc_active, acc_boot_r, acc_dm_r, acc_wr_r, done_r;
	logic [3:0]  acc_cnt_r;
	logic [15:0] acc_addr_r;
	logic [23:0] acc_wdata_r, rdata_r;
	logic        grant_r, grant_eff;
	bbg_state_t  state_r;
	logic [2:0]  boot_page_select_r;
	logic [10:0] word_idx_r;
	logic [1:0]  byte_sel_r;
	logic [15:0] boot_addr;

	// no start while granted or requested: a split pair waits for release
	wire can_start  = strap_cap_r & ~acc_active & ~br_act & ~grant_r; // [RQ19]
	wire boot_start = can_start & (state_r != bs_idle);
	wire core_start = can_start & (state_r == bs_idle) & i_core.req & ~done_r;
	wire acc_last   = acc_active & (acc_cnt_r == 4'h0);

	assign boot_addr = (state_r == bs_len) ? {boot_page_select_r, `BBG_LEN_OFFSET} :
		{boot_page_select_r, word_idx_r, byte_sel_r};  // [RQ3] [RQ4]

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			acc_active  <= 1'b0;
			acc_boot_r  <= 1'b0;
			acc_dm_r    <= 1'b0;
			acc_wr_r    <= 1'b0;
			acc_cnt_r   <= 4'h0;
			acc_addr_r  <= 16'h0000;
			acc_wdata_r <= 24'h000000;
		end else if (boot_start) begin
			acc_active <= 1'b1;
			acc_boot_r <= 1'b1;
			acc_dm_r   <= 1'b0;
			acc_wr_r   <= 1'b0;
			acc_cnt_r  <= {1'b0, wait_r} + `BBG_SYNC_LAT;  // [RQ9] [RQ10]
			acc_addr_r <= boot_addr;
		end else if (core_start) begin
			acc_active  <= 1'b1;
			acc_boot_r  <= 1'b0;
			acc_dm_r    <= i_core.is_dm;
			acc_wr_r    <= i_core.wr;
			acc_cnt_r   <= {1'b0, i_core.ws} + `BBG_SYNC_LAT;
			acc_addr_r  <= {2'h0, i_core.addr};
			acc_wdata_r <= i_core.wdata;
		end else if (acc_last) begin
			acc_active <= 1'b0;
		end else if (acc_active) begin
			acc_cnt_r <= acc_cnt_r - 4'h1;
		end
	end

	// core completion
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			done_r  <= 1'b0;
			rdata_r <= 24'h000000;
		end else begin
			done_r <= acc_last & ~acc_boot_r;
			if (acc_last & ~acc_boot_r & ~acc_wr_r)
				rdata_r <= din_s2_r;
		end
	end

	// boot sequencer
	logic [7:0]  len_r;
	logic [15:0] word_buf_r;
	wire  [7:0]  boot_byte = din_s2_r[`BBG_LANE_MSB:`BBG_LANE_LSB];  // [RQ12]
	wire         boot_done = acc_last & acc_boot_r;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r    <= bs_idle;
			boot_page_select_r    <= `BBG_PAGE_RST;
			len_r      <= 8'h00;
			word_idx_r <= 11'h000;
			byte_sel_r <= `BBG_BYTE_HI;
			word_buf_r <= 16'h0000;
		end else begin
			unique case (state_r)
				bs_idle: begin
					if (reset_boot) begin
						boot_page_select_r <= `BBG_PAGE_RST;  // [RQ7]
						state_r <= bs_len;
					end else if (force_pulse) begin
						boot_page_select_r <= i_avs_writedata[`BBG_PAGE_MSB:`BBG_PAGE_LSB]; // [RQ8]
						state_r <= bs_len;
					end
				end
				bs_len: begin
					if (boot_done) begin
						len_r      <= boot_byte;  // [RQ5]
						word_idx_r <= {boot_byte, `BBG_TOP_WORD_LSB};  // [RQ6]
						byte_sel_r <= `BBG_BYTE_HI;
						state_r    <= bs_word;
					end
				end
				bs_word: begin
					if (boot_done) begin
						// offset 4k+3 is the word's top byte, 4k+0 is padding
						unique case (byte_sel_r)
							`BBG_BYTE_HI:  word_buf_r[15:8] <= boot_byte;
							`BBG_BYTE_MID: word_buf_r[7:0]  <= boot_byte;
							default: ;
						endcase
						if (byte_sel_r == `BBG_BYTE_LO) begin  // [RQ4]
							byte_sel_r <= `BBG_BYTE_HI;
							if (word_idx_r == 11'h000)
								state_r <= bs_idle;
							else
								word_idx_r <= word_idx_r - 11'h001;  // [RQ5]
						end else begin
							byte_sel_r <= byte_sel_r - 2'h1;
						end
					end
				end
			endcase
		end
	end

	// program memory write port
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pm <= '0;
		end else begin
			o_pm.we <= boot_done & (state_r == bs_word) &
				(byte_sel_r == `BBG_BYTE_LO);  // [RQ2] [RQ4]
			o_pm.addr <= word_idx_r;
			o_pm.data <= {word_buf_r, boot_byte};
		end
	end

	// bus grant: registered in idle cycle, dropped combinationally on release
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			grant_r <= 1'b0;
		else
			grant_r <= br_act & ~acc_active;  // [RQ15] [RQ18] [RQ22]
	end
	// under reset the flop is held, so grant follows the request directly
	assign grant_eff = br_act & (grant_r | ~i_rst_n);  // [RQ20] [RQ21]
	assign o_bus_grant_n = ~grant_eff;

	wire boot_busy = (state_r != bs_idle);
	wire core_run  = strap_cap_r & ~boot_busy;
	wire blocked   = grant_eff & (boot_busy | i_core.req);
	assign o_grant_hang_n = ~blocked;  // [RQ23]

	// halt only stops core stepping; serial ports and core state unaffected
	assign o_core.halt = ~core_run | acc_active | core_start |
		(grant_eff & (~i_core.go_mode | i_core.req));  // [RQ15] [RQ16] [RQ17]
	assign o_core.run   = core_run;
	assign o_core.done  = done_r;
	assign o_core.rdata = rdata_r;

	// external pins, released while granted
	always_comb begin
		o_ext            = '0;
		o_ext.pms_n      = 1'b1;
		o_ext.dms_n      = 1'b1;
		o_ext.bms_n      = 1'b1;
		o_ext.rd_n       = 1'b1;
		o_ext.wr_n       = 1'b1;
		o_ext.strobe_oe  = ~grant_eff;  // [RQ15]
		o_ext.addr       = acc_addr_r[13:0];  // [RQ11]
		o_ext.dout       = acc_wdata_r;
		if (acc_active & ~grant_eff) begin
			o_ext.addr_oe = 1'b1;
			o_ext.rd_n    = acc_wr_r;
			o_ext.wr_n    = ~acc_wr_r;
			if (acc_boot_r) begin
				o_ext.bms_n      = 1'b0;  // [RQ10]
				o_ext.dout[23:22] = acc_addr_r[15:14];  // [RQ11]
				o_ext.dout_oe_hi = 1'b1;
			end else begin
				o_ext.pms_n      = acc_dm_r;
				o_ext.dms_n      = ~acc_dm_r;
				o_ext.dout_oe_hi = acc_wr_r;
				o_ext.dout_oe_lo = acc_wr_r;
			end
		end
	end

	assign o_mode.relocate    = mode_ext_r;
	assign o_mode.pm_ram_base = mode_ext_r ? `BBG_RELOC_BASE :
		`BBG_NORMAL_BASE;  // [RQ13]
	assign o_mode.start_addr  = `BBG_EXT_START;
	assign o_mode.illegal     = mode_bad_r;

	// avalon slave: reads take one wait cycle, writes none
	logic rd_ack_r;
	logic [31:0] status, rd_mux;
	always_comb begin
		status = 32'h00000000;
		status[`BBG_ST_BUSY]     = boot_busy;
		status[`BBG_ST_GRANT]    = grant_eff;
		status[`BBG_ST_HANG]     = blocked;
		status[`BBG_ST_BOOTMODE] = mode_boot_r;
		status[`BBG_ST_EXTMODE]  = mode_ext_r;
		status[`BBG_ST_ILLEGAL]  = mode_bad_r;
		status[`BBG_ST_RUN]      = core_run;
		rd_mux = 32'h00000000;
		if (i_avs_address == `BBG_REG_SYSCTL) begin
			rd_mux[`BBG_PAGE_MSB:`BBG_PAGE_LSB] = page_r;
			rd_mux[`BBG_FORCE_BIT]              = boot_busy;
			rd_mux[`BBG_WAIT_MSB:`BBG_WAIT_LSB] = wait_r;
		end else if (i_avs_address == `BBG_REG_STATUS) begin
			rd_mux = status;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_ack_r       <= 1'b0;
			o_avs_readdata <= 32'h00000000;
		end else begin
			rd_ack_r <= i_avs_read & ~rd_ack_r;
			if (i_avs_read & ~rd_ack_r)
				o_avs_readdata <= rd_mux;
		end
	end
	assign o_avs_waitrequest = i_avs_read & ~rd_ack_r;

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	property p_grant_next;
		br_act && !acc_active && !grant_r |=> grant_eff || !br_act;
	endproperty
	a_grant_next: assert property (p_grant_next) // [RQ15]
		else $error("grant not given one cycle after idle request");

	property p_grant_drop;
		!br_act |-> o_bus_grant_n;
	endproperty
	a_grant_drop: assert property (p_grant_drop) // [RQ20]
		else $error("grant held after request released");

	property p_no_start_granted;
		acc_active && !$past(acc_active) |-> !$past(grant_r) && !$past(br_act);
	endproperty
	a_no_start_granted: assert property (p_no_start_granted) // [RQ19]
		else $error("access started while bus requested or granted");

	property p_boot_wait;
		acc_active && !$past(acc_active) && acc_boot_r |->
			acc_cnt_r == {1'b0, $past(wait_r)} + `BBG_SYNC_LAT;
	endproperty
	a_boot_wait: assert property (p_boot_wait) // [RQ9]
		else $error("boot access length ignores wait states");

	property p_boot_strobe;
		acc_active && acc_boot_r && !grant_eff |->
			!o_ext.bms_n && o_ext.pms_n && o_ext.dms_n && !o_ext.rd_n;
	endproperty
	a_boot_strobe: assert property (p_boot_strobe) // [RQ10]
		else $error("boot access without boot strobe alone");

	property p_boot_upper;
		acc_active && acc_boot_r && !grant_eff |->
			o_ext.dout[23:22] == acc_addr_r[15:14] && o_ext.dout_oe_hi;
	endproperty
	a_boot_upper: assert property (p_boot_upper) // [RQ11]
		else $error("upper boot address bits not on data bus");

	property p_no_grant_in_access;
		acc_active |-> !grant_r ##1 !grant_r;
	endproperty
	a_no_grant_in_access: assert property (p_no_grant_in_access) // [RQ22]
		else $error("bus granted before access completed");

	property p_len_first;
		state_r == bs_word && $past(state_r) == bs_len |->
			word_idx_r == {len_r, `BBG_TOP_WORD_LSB} && $past(acc_addr_r[12:0])
			== `BBG_LEN_OFFSET;
	endproperty
	a_len_first: assert property (p_len_first) // [RQ6]
		else $error("word count not derived from length byte");

	property p_hang;
		grant_eff && i_core.req |-> !o_grant_hang_n;
	endproperty
	a_hang: assert property (p_hang) // [RQ23]
		else $error("hang not shown while blocked by grant");

	property p_reset_page0;
		reset_boot |=> state_r == bs_len && boot_page_select_r == `BBG_PAGE_RST;
	endproperty
	a_reset_page0: assert property (p_reset_page0) // [RQ7]
		else $error("reset boot did not load page zero");
endmodule : bbg_top
`default_nettype wire

// ==== testbench/bbg_eprom.sv ====
// byte-wide boot memory model answering on the middle data lane
`timescale 1ns/1ps
`default_nettype none
module bbg_eprom (
	input  wire logic                  i_clk,
	input  wire bbg_pkg::bbg_ext_out_t i_ext,
	output logic [23:0]                o_data
);
	import bbg_pkg::*;
	logic [23:0] last_r;
	logic [15:0] baddr;
	logic [7:0]  byte_v;
	initial last_r = 24'h0;
	assign baddr = {i_ext.dout[23:22], i_ext.addr};
	always_comb begin
		if (baddr[12:0] == 13'h0)
			byte_v = {7'h0, baddr[15:13] == 3'h5};
		else
			byte_v = baddr[7:0] ^ baddr[15:8];
		// idle bus flips every cycle so a stale capture shows up
		o_data = ~last_r;
		if (!i_ext.bms_n && !i_ext.rd_n)
			o_data[15:8] = byte_v;
	end
	always @(posedge i_clk) last_r <= o_data;
endmodule : bbg_eprom
`default_nettype wire

// ==== testbench/tb.sv ====
// testbench: boot loading, bus grant and register checks
`timescale 1ns/1ps
`default_nettype none
`include "bbg_map.svh"
module tb;
	import bbg_pkg::*;
	logic          i_clk, i_rst_n, rd, wr, memory_map_strap, bsrc, br_n, wreq;
	logic          grant_n, hang_n;
	logic [3:0]    addr;
	logic [31:0]   wdata, rdata, rv;
	logic [23:0]   din;
	logic [16:0]   key, pkey;
	bbg_ext_out_t  ext;
	bbg_core_req_t core;
	bbg_core_rsp_t rsp;
	bbg_pm_wr_t    pm;
	bbg_mode_t     mode;
	int            bad_count, comparisons, cyc, run, last_run;
	logic [34:0]   pmq[$];
	logic [15:0]   aq[$];

	bbg_top u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
		.i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .i_memory_map_strap(memory_map_strap),
		.i_boot_source_strap(bsrc), .i_bus_request_n(br_n),
		.o_bus_grant_n(grant_n), .o_grant_hang_n(hang_n), .i_data_in(din),
		.o_ext(ext), .i_core(core), .o_core(rsp), .o_pm(pm), .o_mode(mode));
	bbg_eprom u_mem (.i_clk(i_clk), .i_ext(ext), .o_data(din));

	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [7:0] bf(input logic [15:0] a);
		if (a[12:0] == 13'h0)
			return {7'h0, a[15:13] == 3'h5};
		return a[7:0] ^ a[15:8];
	endfunction : bf

	always @(posedge i_clk) begin
		cyc++;
		key = {ext.bms_n, ext.dout[23:22], ext.addr};
		if (pm.we === 1'b1)
			pmq.push_back({pm.addr, pm.data});
		if (ext.bms_n === 1'b0 && key === pkey) begin
			run++;
		end else begin
			if (run != 0)
				last_run = run;
			run = (ext.bms_n === 1'b0);
			if (ext.bms_n === 1'b0)
				aq.push_back(key[15:0]);
		end
		pkey = key;
		if (ext.bms_n === 1'b0)
			chk({ext.pms_n, ext.dms_n}, 2'b11);
		if (ext.pms_n === 1'b0)
			chk({ext.bms_n, ext.addr_oe, ext.addr},
				{2'b11, 14'h0123});
		if (grant_n === 1'b0)
			chk({ext.addr_oe, ext.dout_oe_hi, ext.dout_oe_lo,
				ext.strobe_oe}, 4'h0);
		if (cyc > 60000) begin
			bad_count++;
			results();
		end
	end

	task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		do @(posedge i_clk); while (wreq !== 1'b0);
		wr <= 1'b0;
	endtask : av_wr

	task automatic av_rd(input logic [3:0] a);
		@(posedge i_clk);
		addr <= a;
		rd   <= 1'b1;
		do @(posedge i_clk); while (wreq !== 1'b0);
		rv = rdata;
		rd <= 1'b0;
	endtask : av_rd

	task automatic do_reset(input logic m, input logic b);
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		memory_map_strap    <= m;
		bsrc    <= b; // board never straps b high with m low
		repeat (20) @(posedge i_clk);
		i_rst_n <= 1'b1;
	endtask : do_reset

	// bounded wait on the grant pin, counted in whole clock cycles sampled at the falling edge
	task automatic wait_grant(input logic v, input int n);
		int k;
		k = 0;
		while (grant_n !== v && k < n) begin
			@(negedge i_clk);
			k++;
		end
		chk(grant_n, v);
	endtask : wait_grant

	task automatic wait_boot();
		int n;
		n = 0;
		do begin
			av_rd(`BBG_REG_STATUS);
			n++;
		end while (rv[`BBG_ST_BUSY] !== 1'b0 && n < 400);
		chk(n < 400, 1'b1);
	endtask : wait_boot

	task automatic check_boot(input logic [2:0] pg, input int ln,
		input int ws);
		int          nw;
		logic [15:0] b;
		logic [23:0] e;
		nw = (ln + 1) * 8;
		chk(pmq.size(), nw);
		chk(aq.size(), 1 + 3 * nw);
		chk(aq[0], {pg, 13'h0});
		chk(aq[1], {pg, 13'h0} + 16'(4 * nw - 1));
		chk(last_run, ws + 3);
		for (int i = 0; i < nw && i < pmq.size(); i++) begin
			b = {pg, 13'h0} + 16'((nw - 1 - i) * 4);
			e = {bf(b + 16'h3), bf(b + 16'h2), bf(b + 16'h1)};
			chk(pmq[i], {11'(nw - 1 - i), e});
		end
		pmq.delete();
		aq.delete();
	endtask : check_boot

	initial begin
		i_rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		memory_map_strap = 1'b0;
		bsrc = 1'b0;
		br_n = 1'b1;
		core = '0;
		pkey = '1;
		do_reset(1'b0, 1'b0);
		wait_boot();
		check_boot(3'h0, 0, 7);
		av_rd(`BBG_REG_SYSCTL);
		chk(rv[6:0], {3'h7, 1'b0, 3'h0});
		av_rd(`BBG_REG_STATUS);
		chk(rv[`BBG_ST_BOOTMODE], 1'b1);
		av_wr(`BBG_REG_SYSCTL, 32'h0000_000d);
		wait_boot();
		check_boot(3'h5, 1, 0);
		av_wr(`BBG_REG_SYSCTL, 32'h0000_0028);
		repeat (40) @(posedge i_clk);
		br_n <= 1'b0; // outside master only asks, never drives
		wait_grant(1'b0, 12);
		b_hold();
		br_n <= 1'b1;
		wait_grant(1'b1, 3);
		wait_boot();
		check_boot(3'h0, 0, 2);
		@(posedge i_clk);
		br_n <= 1'b0;
		wait_grant(1'b0, 4);
		@(posedge i_clk);
		core.go_mode <= 1'b1;
		repeat (2) @(negedge i_clk);
		chk(rsp.halt, 1'b0);
		@(posedge i_clk);
		core.addr    <= 14'h0123;
		core.ws      <= 3'h3;
		core.req     <= 1'b1;
		repeat (4) @(negedge i_clk);
		chk(hang_n, 1'b0);
		chk(rsp.done, 1'b0);
		chk(rsp.halt, 1'b1);
		@(posedge i_clk);
		br_n <= 1'b1;
		wait_grant(1'b1, 3);
		begin : core_wait
			int k;
			k = 0;
			do begin
				@(negedge i_clk);
				k++;
			end while (rsp.done !== 1'b1 && k < 30);
			chk(rsp.done, 1'b1);
			chk(hang_n, 1'b1);
		end
		@(posedge i_clk);
		core.req <= 1'b0;
		do_reset(1'b1, 1'b0);
		av_rd(`BBG_REG_STATUS);
		chk(rv[`BBG_ST_EXTMODE:`BBG_ST_BUSY], 5'h10);
		chk({mode.relocate, mode.pm_ram_base, mode.start_addr},
			{1'b1, 14'h3800, 14'h0000});
		av_rd(4'h8);
		chk(rv, 32'h0);
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		br_n    <= 1'b0;
		repeat (2) @(posedge i_clk);
		wait_grant(1'b0, 2);
		@(posedge i_clk);
		br_n <= 1'b1;
		wait_grant(1'b1, 3);
		@(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (5) @(posedge i_clk);
		results();
	end

	// boot must stand still while the bus is handed away
	task automatic b_hold();
		int n;
		n = pmq.size();
		repeat (20) @(posedge i_clk);
		chk(pmq.size(), n);
		@(posedge i_clk);
	endtask : b_hold
endmodule : tb
`default_nettype wire
